// ### rtl/region_protection_unit.sv
// region protection checker for the static RAM and peripheral bridge ports
// Function
// - sixteen descriptors of four 32-bit words each are held and written by software.
// - each descriptor bounds its region by a start and an end address, 32 bytes up to 4 GB.
// - after reset checking is off and every access passes.
// - the core master is checked against supervisor or user read, write and execute bits.
// - every other master is checked against one read and one write bit.
// - the valid bit is cleared by hardware on writes to words 0 to 2 and set by word 3.
// - an alias of each access word changes permissions only.
// - with overlapping regions any granting region grants the access.
// - both monitored ports are checked against all descriptors at once.
// - an access with sufficient rights is forwarded to its slave.
// - an access hitting no valid region or denied by all hits is an error.
// - an error gets an error response and never reaches the slave.
// - each port keeps a 64-bit record of address and details of its last fault.
`timescale 1ns/1ps
`default_nettype none
`include "rpu_consts.svh"
module region_protection_unit (
    input  wire logic                       I_CORE_CLK,
    input  wire logic                       I_RESET,
    input  wire logic                       I_CE,
    input  wire logic                       I_PSEL,
    input  wire logic                       I_PENABLE,
    input  wire logic                       I_PWRITE,
    input  wire rpu_pkg::word_t             I_PADDR,
    input  wire rpu_pkg::word_t             I_PWDATA,
    output logic                            O_PREADY,
    output rpu_pkg::word_t                  O_PRDATA,
    output logic                            O_PSLVERR,
    input  wire logic [1:0]                 I_ACC_VALID,
    input  wire logic [1:0][31:0]           I_ACC_ADDR,
    input  wire logic [1:0]                 I_ACC_WRITE,
    input  wire logic [1:0]                 I_ACC_EXEC,
    input  wire logic [1:0]                 I_ACC_SUPER,
    input  wire logic [1:0][1:0]            I_ACC_MASTER,
    output logic [1:0]                      O_SLV_REQ,
    output logic [1:0][31:0]                O_SLV_ADDR,
    output logic [1:0]                      O_SLV_WRITE,
    output logic [1:0]                      O_ACC_ERR,
    output logic                            O_IRQ
);
    import rpu_pkg::*;
    localparam int NR = `RPU_NUM_REGIONS;
    localparam int NP = `RPU_NUM_PORTS;

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    logic                         enable;
    gaddr_t                       rstart [NR];
    gaddr_t                       rend   [NR];
    logic [`RPU_ACW_BITS-1:0]     acw    [NR];
    logic [NR-1:0]                rvalid;
    word_t                        err_addr [NP];
    word_t                        err_det  [NP];
    logic [NP-1:0]                status;
    logic [NP-1:0]                irq_en;
    logic [NP-1:0]                next_status;
    logic [NP-1:0]                fault;
    logic [NP-1:0]                allowed;
    logic [NR-1:0]                hit   [NP];
    logic [NR-1:0]                grant [NP];
    word_t                        next_rdata;
    logic                         next_slverr;

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    logic       wr;
    logic       rd;
    logic [11:0] a;
    logic       desc_sel;
    logic       alias_sel;
    logic [3:0] desc_idx;
    logic [3:0] alias_idx;

    assign a         = I_PADDR[11:0];
    assign wr        = I_CE && I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    assign rd        = I_CE && I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE;
    assign desc_sel  = (a[11:10] == `RPU_DESC_PAGE) && (a[9:8] == 2'h0);
    assign alias_sel = (a[11:8] == `RPU_ALIAS_PAGE) && (a[7:6] == 2'h0);
    assign desc_idx  = a[7:4];
    assign alias_idx = a[5:2];

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PREADY <= 1'b0;
        end else if (I_CE) begin
            O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
        end
    end

    always_comb begin
        next_rdata  = 32'h0000_0000;
        next_slverr = 1'b0;
        if (desc_sel) begin
            unique case (a[3:2])
                `RPU_W_START:  next_rdata = {rstart[desc_idx], 5'h00};
                `RPU_W_END:    next_rdata = {rend[desc_idx], 5'h1F};
                `RPU_W_ACCESS: next_rdata = {20'h0_0000, acw[desc_idx]};
                `RPU_W_VALID:  next_rdata = {31'h0000_0000, rvalid[desc_idx]};
            endcase
        end else if (alias_sel) begin
            next_rdata = {20'h0_0000, acw[alias_idx]};
        end else begin
            unique case (a)
                `RPU_CTRL_OFS:  next_rdata = {31'h0000_0000, enable};
                `RPU_ERR0_ADDR: next_rdata = err_addr[0];
                `RPU_ERR0_DET:  next_rdata = err_det[0];
                `RPU_ERR1_ADDR: next_rdata = err_addr[1];
                `RPU_ERR1_DET:  next_rdata = err_det[1];
                `RPU_STAT_OFS:  next_rdata = {30'h0000_0000, status};
                `RPU_CLR_OFS:   next_rdata = 32'h0000_0000;
                `RPU_IEN_OFS:   next_rdata = {30'h0000_0000, irq_en};
                default:        next_slverr = 1'b1;
            endcase
        end
    end

    // read data and error are loaded together with ready
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (I_CE) begin
            O_PRDATA  <= rd ? next_rdata : 32'h0000_0000;
            O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && next_slverr;
        end
    end

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            enable <= 1'b0;
            irq_en <= 2'h0;
        end else if (wr && !desc_sel && !alias_sel) begin
            if (a == `RPU_CTRL_OFS) enable <= I_PWDATA[0];
            if (a == `RPU_IEN_OFS) irq_en <= I_PWDATA[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // descriptors
    // ------------------------------------------------------------------------
    generate
        for (genvar r = 0; r < NR; r++) begin : g_desc
            logic hit_w;
            logic hit_a;
            assign hit_w = wr && desc_sel && (desc_idx == 4'(r));
            assign hit_a = wr && alias_sel && (alias_idx == 4'(r));
            always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    rstart[r] <= `RPU_ADDR_RESET;
                    rend[r]   <= `RPU_ADDR_RESET;
                    acw[r]    <= `RPU_ACW_RESET;
                    rvalid[r] <= 1'b0;
                end else if (hit_w) begin
                    unique case (a[3:2])
                        `RPU_W_START: begin
                            rstart[r] <= I_PWDATA[31:`RPU_GRAN_LSB];
                            rvalid[r] <= 1'b0;
                        end
                        `RPU_W_END: begin
                            rend[r]   <= I_PWDATA[31:`RPU_GRAN_LSB];
                            rvalid[r] <= 1'b0;
                        end
                        `RPU_W_ACCESS: begin
                            acw[r]    <= I_PWDATA[`RPU_ACW_BITS-1:0];
                            rvalid[r] <= 1'b0;
                        end
                        `RPU_W_VALID: rvalid[r] <= I_PWDATA[0];
                    endcase
                end else if (hit_a) begin
                    // permissions only, bounds and valid untouched
                    acw[r] <= I_PWDATA[`RPU_ACW_BITS-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // access checking, both ports against every region in parallel
    // ------------------------------------------------------------------------
    generate
        for (genvar p = 0; p < NP; p++) begin : g_port
            for (genvar r = 0; r < NR; r++) begin : g_reg
                region_match u_match (
                    .i_valid  (rvalid[r]),
                    .i_start  (rstart[r]),
                    .i_end    (rend[r]),
                    .i_acw    (acw[r]),
                    .i_addr   (I_ACC_ADDR[p]),
                    .i_write  (I_ACC_WRITE[p]),
                    .i_exec   (I_ACC_EXEC[p]),
                    .i_super  (I_ACC_SUPER[p]),
                    .i_master (master_e'(I_ACC_MASTER[p])),
                    .o_hit    (hit[p][r]),
                    .o_grant  (grant[p][r])
                );
            end
            // one granting region is enough
            assign allowed[p] = !enable || (|grant[p]);
            assign fault[p]   = I_ACC_VALID[p] && !allowed[p];

            always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    O_SLV_REQ[p]   <= 1'b0;
                    O_SLV_ADDR[p]  <= 32'h0000_0000;
                    O_SLV_WRITE[p] <= 1'b0;
                    O_ACC_ERR[p]   <= 1'b0;
                end else if (I_CE) begin
                    O_SLV_REQ[p] <= I_ACC_VALID[p] && allowed[p];
                    O_ACC_ERR[p] <= fault[p];
                    if (I_ACC_VALID[p] && allowed[p]) begin
                        O_SLV_ADDR[p]  <= I_ACC_ADDR[p];
                        O_SLV_WRITE[p] <= I_ACC_WRITE[p];
                    end
                end
            end

            always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    err_addr[p] <= 32'h0000_0000;
                    err_det[p]  <= 32'h0000_0000;
                end else if (I_CE && fault[p]) begin
                    err_addr[p] <= I_ACC_ADDR[p];
                    err_det[p]  <= {hit[p], 11'h000, I_ACC_MASTER[p],
                                    I_ACC_SUPER[p], I_ACC_EXEC[p], I_ACC_WRITE[p]};
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // interrupt: sticky status, a new fault beats a clear in the same cycle
    // ------------------------------------------------------------------------
    always_comb begin
        next_status = status;
        if (wr && a == `RPU_CLR_OFS) next_status = next_status & ~I_PWDATA[1:0];
        next_status = next_status | fault;
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            status <= 2'h0;
            O_IRQ  <= 1'b0;
        end else if (I_CE) begin
            status <= next_status;
            O_IRQ  <= |(next_status & irq_en);
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_fault1;
        I_CE && I_ACC_VALID[1] && enable && !(|grant[1]);
    endsequence
    sequence s_logged1;
        O_ACC_ERR[1] && !O_SLV_REQ[1] && status[1];
    endsequence

    a_open_after_reset: assert property (I_CE && !enable && I_ACC_VALID[0] |=> O_SLV_REQ[0] && !O_ACC_ERR[0])
        else $error("access blocked while checking is off");
    a_miss_is_error: assert property (I_CE && enable && I_ACC_VALID[0] && !(|hit[0]) |=> O_ACC_ERR[0])
        else $error("access outside every region not flagged");
    a_grant_wins: assert property (I_CE && I_ACC_VALID[0] && (|grant[0]) |=> O_SLV_REQ[0] && !O_ACC_ERR[0])
        else $error("granted access not forwarded");
    a_error_blocks_slave: assert property (O_ACC_ERR[0] |-> !O_SLV_REQ[0])
        else $error("faulting access reached the slave");
    a_port1_fault_logged: assert property (s_fault1 |=> s_logged1)
        else $error("port 1 fault not answered and logged");
    a_record_latest: assert property (I_CE && fault[0] |=> err_addr[0] == $past(I_ACC_ADDR[0]))
        else $error("error record not updated with last fault");
    a_record_held: assert property (!fault[0] |=> $stable(err_addr[0]))
        else $error("error record changed without a fault");
    a_alias_keeps_bounds: assert property (wr && alias_sel && alias_idx == 4'h0
        |=> $stable(rstart[0]) && $stable(rend[0]) && $stable(rvalid[0]))
        else $error("alias write disturbed region bounds");
    a_valid_dropped: assert property (wr && desc_sel && desc_idx == 4'h0 && a[3:2] == `RPU_W_START
        |=> !rvalid[0])
        else $error("valid not cleared by start word write");
    a_apb_one_wait: assert property (I_CE && I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("apb ready late");

    // ------------------------------------------------------------------------
    // rights, bounds, answers and records
    // ------------------------------------------------------------------------

    a_user_write_bit: assert property (hit[0][0] && I_ACC_MASTER[0] == 2'h0 && !I_ACC_SUPER[0]
        && I_ACC_WRITE[0] && !I_ACC_EXEC[0] |-> grant[0][0] == acw[0][`RPU_ACW_USER+1])
        else $error("core user write right misjudged");

    a_super_exec_bit: assert property (hit[0][0] && I_ACC_MASTER[0] == 2'h0 && I_ACC_SUPER[0]
        && I_ACC_EXEC[0] |-> grant[0][0] == acw[0][`RPU_ACW_SUPER+2])
        else $error("core supervisor fetch right misjudged");

    a_dma_read_bit: assert property (hit[0][0] && I_ACC_MASTER[0] == 2'h1 && !I_ACC_WRITE[0]
        |-> grant[0][0] == acw[0][`RPU_ACW_OTHER])
        else $error("dma read right misjudged");

    a_ext_read_bit: assert property (hit[0][0] && I_ACC_MASTER[0] == 2'h2 && !I_ACC_WRITE[0]
        |-> grant[0][0] == acw[0][`RPU_ACW_OTHER+2])
        else $error("external master read right misjudged");

    a_inside_hits: assert property (rvalid[0] && I_ACC_ADDR[0][31:`RPU_GRAN_LSB] >= rstart[0]
        && I_ACC_ADDR[0][31:`RPU_GRAN_LSB] <= rend[0] |-> hit[0][0])
        else $error("address inside region bounds missed");

    a_one_answer: assert property (I_CE |=> (O_SLV_REQ ^ O_ACC_ERR) == $past(I_ACC_VALID))
        else $error("access not answered exactly once");

    a_forward_addr: assert property (I_CE && I_ACC_VALID[0] && (|grant[0])
        |=> O_SLV_REQ[0] && O_SLV_ADDR[0] == $past(I_ACC_ADDR[0]))
        else $error("granted access forwarded wrongly");

    a_record_detail: assert property (I_CE && fault[1] |=> err_det[1][15:0] == {11'h000,
        $past(I_ACC_MASTER[1]), $past(I_ACC_SUPER[1]), $past(I_ACC_EXEC[1]), $past(I_ACC_WRITE[1])})
        else $error("fault attributes not recorded");

    a_status_sticky: assert property (status[0] && !(wr && a == `RPU_CLR_OFS && I_PWDATA[0]) |=> status[0])
        else $error("status bit lost without a clear");

    a_irq_level: assert property (I_CE |=> O_IRQ == |(status & $past(irq_en)))
        else $error("interrupt level disagrees with status");

    a_freeze_state: assert property (!I_CE |=> $stable(O_SLV_REQ) && $stable(O_ACC_ERR) && $stable(status))
        else $error("state moved while clock enable low");

    a_start_written: assert property (wr && desc_sel && desc_idx == 4'h1 && a[3:2] == `RPU_W_START
        |=> rstart[1] == $past(I_PWDATA[31:`RPU_GRAN_LSB]))
        else $error("start word write lost");

    a_valid_written: assert property (wr && desc_sel && desc_idx == 4'h0 && a[3:2] == `RPU_W_VALID
        |=> rvalid[0] == $past(I_PWDATA[0]))
        else $error("valid word write lost");
endmodule : region_protection_unit
`default_nettype wire

// ### rtl/rpu_consts.svh
// offsets, field positions and reset values of the region protection unit
`ifndef RPU_CONSTS_SVH
`define RPU_CONSTS_SVH
// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define RPU_NUM_REGIONS  16
`define RPU_NUM_PORTS    2
`define RPU_GRAN_LSB     5
// ----------------------------------------------------------------------------
// register byte offsets (low 12 address bits)
// ----------------------------------------------------------------------------
`define RPU_CTRL_OFS     12'h000
`define RPU_ERR0_ADDR    12'h010
`define RPU_ERR0_DET     12'h014
`define RPU_ERR1_ADDR    12'h018
`define RPU_ERR1_DET     12'h01C
`define RPU_STAT_OFS     12'h020
`define RPU_CLR_OFS      12'h024
`define RPU_IEN_OFS      12'h028
`define RPU_DESC_PAGE    2'h1
`define RPU_ALIAS_PAGE   4'h8
// ----------------------------------------------------------------------------
// descriptor words and access control layout
// ----------------------------------------------------------------------------
`define RPU_W_START      2'h0
`define RPU_W_END        2'h1
`define RPU_W_ACCESS     2'h2
`define RPU_W_VALID      2'h3
`define RPU_ACW_BITS     12
`define RPU_ACW_USER     0
`define RPU_ACW_SUPER    3
`define RPU_ACW_OTHER    6
`define RPU_ACW_RESET    12'h000
`define RPU_ADDR_RESET   27'h000_0000
`endif

// ### rtl/rpu_pkg.sv
// types shared by the region protection unit files
package rpu_pkg;
    typedef logic [31:0] word_t;
    typedef logic [26:0] gaddr_t;
    typedef enum logic [1:0] {MST_CORE, MST_DMA, MST_EXT, MST_AUX} master_e;
endpackage : rpu_pkg

// ### rtl/region_match.sv
// one region descriptor compared against one access
`timescale 1ns/1ps
`default_nettype none
`include "rpu_consts.svh"
module region_match (
    input  wire logic                     i_valid,
    input  wire rpu_pkg::gaddr_t          i_start,
    input  wire rpu_pkg::gaddr_t          i_end,
    input  wire logic [`RPU_ACW_BITS-1:0] i_acw,
    input  wire rpu_pkg::word_t           i_addr,
    input  wire logic                     i_write,
    input  wire logic                     i_exec,
    input  wire logic                     i_super,
    input  wire rpu_pkg::master_e         i_master,
    output logic                          o_hit,
    output logic                          o_grant
);
    import rpu_pkg::*;
    logic [2:0] rwx;
    logic       ok;
    // inclusive bounds, low five address bits ignored
    assign o_hit = i_valid && (i_addr[31:`RPU_GRAN_LSB] >= i_start)
                   && (i_addr[31:`RPU_GRAN_LSB] <= i_end);
    always_comb begin
        rwx = 3'h0;
        unique case (i_master)
            MST_CORE: rwx = i_super ? i_acw[`RPU_ACW_SUPER +: 3] : i_acw[`RPU_ACW_USER +: 3];
            MST_DMA:  rwx = {1'b0, i_acw[`RPU_ACW_OTHER +: 2]};
            MST_EXT:  rwx = {1'b0, i_acw[`RPU_ACW_OTHER+2 +: 2]};
            MST_AUX:  rwx = {1'b0, i_acw[`RPU_ACW_OTHER+4 +: 2]};
        endcase
        // non-core masters never fetch: exec is judged as a read for them
        if (i_exec && i_master == MST_CORE) ok = rwx[2];
        else if (i_write) ok = rwx[1];
        else ok = rwx[0];
    end
    assign o_grant = o_hit && ok;
endmodule : region_match
`default_nettype wire

// ### verif/slave_port_model.sv
// behavioural slave behind the two monitored ports: counts forwarded cycles
`timescale 1ns/1ps
`default_nettype none
module slave_port_model (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [1:0]       i_req,
    input  wire logic [1:0][31:0] i_addr,
    output logic      [1:0][15:0] o_count,
    output logic      [1:0][31:0] o_last
);
    // ------------------------------------------------------------------------
    // slave side
    // ------------------------------------------------------------------------
    // accepts at once: a slow slave would not change what the checker forwards
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_count <= '0;
            o_last  <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (i_req[p] === 1'b1) begin
                    o_count[p] <= o_count[p] + 16'h0001;
                    o_last[p]  <= i_addr[p];
                end
            end
        end
    end
endmodule : slave_port_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench: apb register access and monitored port traffic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rpu_pkg::*;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             ce  = 1'b1;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    word_t            paddr = '0, pwdata = '0, prdata, rdata;
    logic             pready, pslverr, irq, last_err;
    logic [1:0]       acc_valid = '0, acc_write = '0, acc_exec = '0, acc_super = '0;
    logic [1:0][31:0] acc_addr = '0, slv_addr, last;
    logic [1:0][1:0]  acc_master = '0;
    logic [1:0]       slv_req, slv_write, acc_err, act = '0;
    logic [1:0][15:0] count;
    int               mismatches = 0, n_checks = 0;
    int               exp_cnt [2] = '{0, 0};
    word_t            t_addr [8] = '{32'h0000_1000, 32'h0000_10FF, 32'h0000_1100, 32'h0000_0FFF,
                                     32'h0000_1000, 32'h0000_1040, 32'h0000_1040, 32'h0000_1040};
    logic [7:0]       t_wr = 8'h50, t_err = 8'hDC;
    logic [7:0][1:0]  t_m = 16'h9400;

    always #10 clk = ~clk;

    region_protection_unit region_protection_unit_inst (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(pslverr), .I_ACC_VALID(acc_valid), .I_ACC_ADDR(acc_addr), .I_ACC_WRITE(acc_write),
        .I_ACC_EXEC(acc_exec), .I_ACC_SUPER(acc_super), .I_ACC_MASTER(acc_master), .O_SLV_REQ(slv_req),
        .O_SLV_ADDR(slv_addr), .O_SLV_WRITE(slv_write), .O_ACC_ERR(acc_err), .O_IRQ(irq));

    slave_port_model slave_port_model_inst (
        .i_clk(clk), .i_reset(rst), .i_req(slv_req), .i_addr(slv_addr), .o_count(count), .o_last(last));

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic results;
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; waits on pready as long as it takes, the watchdog ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input word_t d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {20'h0_0000, a};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata    = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input word_t d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input word_t exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(rdata, exp);
    endtask : rd_chk

    task automatic put(input int p, input word_t a, input logic w, x, s, input logic [1:0] m);
        acc_valid[p]  <= 1'b1;
        acc_addr[p]   <= a;
        acc_write[p]  <= w;
        acc_exec[p]   <= x;
        acc_super[p]  <= s;
        acc_master[p] <= m;
        act[p]         = 1'b1;
    endtask : put

    // outcome of the accesses placed by put, 1 ns after the clock edge that takes them
    task automatic go(input logic [1:0] e);
        @(posedge clk);
        acc_valid <= 2'h0;
        #1;
        for (int p = 0; p < 2; p++) begin
            if (act[p]) begin
                check({31'h0000_0000, acc_err[p]}, {31'h0000_0000, e[p]});
                check({31'h0000_0000, slv_req[p]}, {31'h0000_0000, !e[p]});
                if (!e[p]) check(slv_addr[p], acc_addr[p]);
                if (!e[p]) check({31'h0000_0000, slv_write[p]}, {31'h0000_0000, acc_write[p]});
                if (!e[p]) exp_cnt[p]++;
            end
        end
        act = 2'h0;
    endtask : go

    // ------------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------------
    initial begin
        #200000;
        mismatches++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(12'h000, 32'h0000_0000);
        rd_chk(12'h40C, 32'h0000_0000);
        put(0, 32'h0000_5000, 1'b1, 1'b0, 1'b0, MST_DMA);
        go(2'h0);
        wr(12'h400, 32'h0000_1000);
        wr(12'h404, 32'h0000_10E0);
        wr(12'h408, 32'h0000_0041);
        wr(12'h40C, 32'h0000_0001);
        rd_chk(12'h404, 32'h0000_10FF);
        rd_chk(12'h40C, 32'h0000_0001);
        wr(12'h408, 32'h0000_0041);
        rd_chk(12'h40C, 32'h0000_0000);
        wr(12'h40C, 32'h0000_0001);
        wr(12'h000, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            put(0, t_addr[i], t_wr[i], 1'b0, 1'b0, t_m[i]);
            go({1'b0, t_err[i]});
        end
        rd_chk(12'h010, 32'h0000_1040);
        rd_chk(12'h014, 32'h0001_0010);
        rd_chk(12'h020, 32'h0000_0001);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        wr(12'h028, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 check({31'h0000_0000, irq}, 32'h0000_0001);
        wr(12'h024, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 check({31'h0000_0000, irq}, 32'h0000_0000);
        rd_chk(12'h020, 32'h0000_0000);
        rd_chk(12'h024, 32'h0000_0000);
        wr(12'h800, 32'h0000_0028);
        rd_chk(12'h400, 32'h0000_1000);
        rd_chk(12'h404, 32'h0000_10FF);
        rd_chk(12'h408, 32'h0000_0028);
        rd_chk(12'h40C, 32'h0000_0001);
        put(0, 32'h0000_1000, 1'b0, 1'b1, 1'b1, MST_CORE);
        go(2'h0);
        put(0, 32'h0000_1000, 1'b1, 1'b0, 1'b1, MST_CORE);
        go(2'h1);
        put(0, 32'h0000_1000, 1'b0, 1'b0, 1'b0, MST_CORE);
        go(2'h1);
        wr(12'h410, 32'h0000_1000);
        wr(12'h414, 32'h0000_1FE0);
        wr(12'h418, 32'h0000_0002);
        wr(12'h41C, 32'h0000_0001);
        put(0, 32'h0000_1000, 1'b1, 1'b0, 1'b0, MST_CORE);
        put(1, 32'h0000_1020, 1'b0, 1'b0, 1'b0, MST_CORE);
        go(2'h2);
        rd_chk(12'h018, 32'h0000_1020);
        rd_chk(12'h01C, 32'h0003_0000);
        rd_chk(12'h020, 32'h0000_0003);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        rd_chk(12'h030, 32'h0000_0000);
        check({31'h0000_0000, last_err}, 32'h0000_0001);
        wr(12'h000, 32'h0000_0000);
        // clock enable low: the access waits and nothing answers
        ce <= 1'b0;
        put(1, 32'h0000_9100, 1'b0, 1'b0, 1'b0, MST_DMA);
        @(posedge clk);
        #1 check({28'h000_0000, slv_req, acc_err}, 32'h0000_0000);
        ce <= 1'b1;
        go(2'h0);
        put(1, 32'h0000_9000, 1'b1, 1'b0, 1'b0, MST_EXT);
        go(2'h0);
        @(posedge clk);
        #1;
        check({16'h0000, count[0]}, exp_cnt[0]);
        check({16'h0000, count[1]}, exp_cnt[1]);
        check(last[1], 32'h0000_9000);
        results();
    end
endmodule : testbench
`default_nettype wire
